// ---- design/power_saving_mode_ctrl.sv ----
// How it works
// - each external edge is latched every machine cycle, evaluated the next one
// - vectoring waits at least twelve full machine cycles after the request
// - sleep halts the cpu while oscillators and peripheral clocks keep running; buzzer/adc and watchdog stop
// - writing 0F to the standby select register enters sleep
// - stop is entered only by the stop instruction with 5A loaded
// - sleep ends on reset or any enabled interrupt
// - reset reinitialises control registers; interrupt wake keeps them
// - wake with master enable set vectors; otherwise resumes at the next instruction
// - on wake the interval timer counts 00 to FF; overflow resumes operation
// - stop halts main oscillator, system and peripheral clocks; rc watchdog runs
// - stop retains RAM, registers, latches and port drive
// - while stopped the program counter holds the next address
// - in stop timers halt unless event counting; watchdog only in rc mode
// - in sleep and stop serial units run only from an external clock
// - stop releases on reset, external, event timer, watch, watchdog, serial, uart
// - master enable and per-source enables together gate maskable interrupts
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_save_consts.svh"

module power_saving_mode_ctrl
    import pwr_save_pkg::*;
#(
    parameter int MCYC_DIV = `MCYC_DIV_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        stop_exec,
    input  wire logic        master_irq_en,
    input  wire logic [3:0]  ext_irq_pins,
    input  wire logic        periph_irq,
    input  wire logic        event_counter_inputs,
    input  wire logic        watch_wake,
    input  wire logic        wdt_wake,
    input  wire logic        sio_wake,
    input  wire logic        uart_wake,
    output logic             cpu_run,
    output logic             pc_hold,
    output logic             main_osc_en,
    output logic             sys_clk_en,
    output logic             periph_clk_en,
    output logic             timer_clk_en,
    output logic             wdt_clk_en,
    output logic             buzzer_adc_en,
    output logic             serial_int_clk_en,
    output logic             port_hold,
    output logic             irq_vector,
    output logic      [1:0]  irq_vector_src,
    output logic             resume_next
);

    initial begin
        if (MCYC_DIV < 1 || MCYC_DIV > 255) begin
            $error("MCYC_DIV out of range");
        end
    end

    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    pwr_state_t  state_r;
    logic [7:0]  standby_select_register;
    logic [7:0]  clock_control_register;
    logic [15:0] irq_ctrl_r;
    logic [3:0]  ext_irq_request_flags;
    logic [3:0]  pins_prev_r;
    logic [3:0]  edge_seen_r;
    logic [7:0]  mcyc_cnt_r;
    logic        mcyc_en;
    logic [3:0]  resp_cnt_r;
    logic        resp_busy_r;
    logic [1:0]  resp_src_r;
    logic        polled_r;
    logic [7:0]  bit_cnt_r;
    logic [7:0]  bit_pre_r;
    logic        bit_tick;
    logic        bit_ovf;
    logic [3:0]  irq_enable;
    logic [3:0]  pending;
    logic        wake_sleep;
    logic        wake_stop;
    logic        wr_acc;
    logic        rd_acc;
    logic        mapped;
    logic        sleep_req;
    logic        stop_req;
    logic [3:0]  ack_clr;
    logic [3:0]  sw_clr;
    logic        rc_wd;
    logic        ec_mode;
    logic [2:0]  pre_sel;

    // clocks from the start of the call until the vector, less the quiet run checked first
    localparam int RESP_TAIL = `RESP_MCYC * MCYC_DIV - 7;

    assign irq_enable = irq_ctrl_r[`IR_ENABLE_MSB:`IR_ENABLE_LSB];
    assign rc_wd      = clock_control_register[`CK_RC_WATCHDOG];
    assign ec_mode    = clock_control_register[`CK_EVENT_COUNTER];
    assign pre_sel    = clock_control_register[`CK_PRESCALE_MSB:`CK_PRESCALE_LSB];

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    // read data loads in the setup cycle so it already stands in the access phase
    assign rd_acc = psel && !penable && !pwrite;

    always_comb begin
        if (paddr == `OFS_STANDBY_SEL) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_CLOCK_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_IRQ_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_STATUS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel && penable && !mapped;

    // whole-byte writes only; there is no bit path into this register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_select_register <= `STANDBY_RST;
        end else if (wr_acc && paddr == `OFS_STANDBY_SEL) begin
            standby_select_register <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_control_register <= `CLOCK_CTRL_RST;
            irq_ctrl_r             <= `IRQ_CTRL_RST;
        end else if (wr_acc && paddr == `OFS_CLOCK_CTRL) begin
            clock_control_register <= pwdata[7:0];
        end else if (wr_acc && paddr == `OFS_IRQ_CTRL) begin
            irq_ctrl_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_acc) begin
            if (paddr == `OFS_STANDBY_SEL) begin
                prdata <= {24'h000000, standby_select_register};
            end else if (paddr == `OFS_CLOCK_CTRL) begin
                prdata <= {24'h000000, clock_control_register};
            end else if (paddr == `OFS_IRQ_CTRL) begin
                prdata <= {16'h0000, irq_ctrl_r};
            end else if (paddr == `OFS_STATUS) begin
                prdata <= {16'h0000, bit_cnt_r, ext_irq_request_flags, state_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // only the exact codes act; anything else is just stored
    assign sleep_req = wr_acc && paddr == `OFS_STANDBY_SEL
                       && pwdata[7:0] == `CODE_SLEEP;
    assign stop_req  = stop_exec && standby_select_register == `CODE_STOP;

    // ---------------------------------------------------------------
    // machine cycle divider
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcyc_cnt_r <= 8'h00;
        end else if (state_r == ST_STOP) begin
            mcyc_cnt_r <= 8'h00;
        end else if (mcyc_en) begin
            mcyc_cnt_r <= 8'h00;
        end else begin
            mcyc_cnt_r <= mcyc_cnt_r + 8'h01;
        end
    end

    assign mcyc_en = (state_r != ST_STOP) && (mcyc_cnt_r == 8'(MCYC_DIV - 1));

    // ---------------------------------------------------------------
    // external edge capture
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_prev_r <= 4'h0;
        end else begin
            pins_prev_r <= ext_irq_pins;
        end
    end

    // edges between machine cycle boundaries are gathered, then latched
    // into the flags on the boundary; in stop the edge latches at once
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            edge_mode_t mode;
            logic       hit;
            assign mode = edge_mode_t'(irq_ctrl_r[`IR_EDGE_LSB + 2*gi +: 2]);
            assign hit  = (mode == EDGE_RISE && ext_irq_pins[gi] && !pins_prev_r[gi])
                       || (mode == EDGE_FALL && !ext_irq_pins[gi] && pins_prev_r[gi])
                       || (mode == EDGE_BOTH && ext_irq_pins[gi] != pins_prev_r[gi]);

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    edge_seen_r[gi] <= 1'b0;
                end else if (mcyc_en || state_r == ST_STOP) begin
                    // a boundary edge goes straight to the flag; keeping it would latch it twice
                    edge_seen_r[gi] <= 1'b0;
                end else if (hit) begin
                    edge_seen_r[gi] <= 1'b1;
                end
            end

            assign sw_clr[gi]  = wr_acc && paddr == `OFS_STATUS && pwdata[`ST_FLAGS_LSB + gi];
            assign ack_clr[gi] = irq_vector && irq_vector_src == 2'(gi);

            // set wins over any clear in the same cycle
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ext_irq_request_flags[gi] <= 1'b0;
                end else if ((mcyc_en || state_r == ST_STOP) && (edge_seen_r[gi] || hit)) begin
                    ext_irq_request_flags[gi] <= 1'b1;
                end else if (sw_clr[gi] || ack_clr[gi]) begin
                    ext_irq_request_flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign pending = ext_irq_request_flags & irq_enable;

    // ---------------------------------------------------------------
    // response timing
    // ---------------------------------------------------------------
    // flags are polled one machine cycle after the latch, then the call
    // takes twelve machine cycles before the first routine instruction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            polled_r    <= 1'b0;
            resp_busy_r <= 1'b0;
            resp_cnt_r  <= 4'h0;
            resp_src_r  <= 2'h0;
            irq_vector  <= 1'b0;
        end else begin
            irq_vector <= 1'b0;
            if (state_r != ST_ACTIVE) begin
                polled_r    <= 1'b0;
                resp_busy_r <= 1'b0;
                resp_cnt_r  <= 4'h0;
            end else if (resp_busy_r) begin
                if (mcyc_en) begin
                    if (resp_cnt_r == 4'(`RESP_MCYC - 1)) begin
                        resp_busy_r <= 1'b0;
                        resp_cnt_r  <= 4'h0;
                        irq_vector  <= 1'b1;
                    end else begin
                        resp_cnt_r <= resp_cnt_r + 4'h1;
                    end
                end
            end else if (mcyc_en) begin
                polled_r <= master_irq_en && (pending != 4'h0);
                if (polled_r && master_irq_en && pending != 4'h0) begin
                    resp_busy_r <= 1'b1;
                    resp_src_r  <= pending[0] ? 2'h0 : pending[1] ? 2'h1 :
                                   pending[2] ? 2'h2 : 2'h3;
                end
            end
        end
    end

    assign irq_vector_src = resp_src_r;

    // ---------------------------------------------------------------
    // wake sources
    // ---------------------------------------------------------------
    // flags need not pass the master enable to wake; it only picks the exit
    assign wake_sleep = (pending != 4'h0) || periph_irq;
    assign wake_stop  = (pending != 4'h0)
                      || (ec_mode && event_counter_inputs)
                      || watch_wake
                      || (rc_wd && wdt_wake)
                      || sio_wake
                      || uart_wake;

    // ---------------------------------------------------------------
    // basic interval timer for stabilisation
    // ---------------------------------------------------------------
    // prescaler divides by 2^(sel+1); software picks a long enough ratio
    assign bit_tick = (bit_pre_r == 8'((16'h0002 << pre_sel) - 16'h0001));
    assign bit_ovf  = (state_r == ST_STAB) && bit_tick && bit_cnt_r == `BIT_LAST;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_pre_r <= 8'h00;
            bit_cnt_r <= `BIT_START;
        end else if (state_r == ST_STAB) begin
            if (bit_tick) begin
                bit_pre_r <= 8'h00;
                bit_cnt_r <= bit_cnt_r + 8'h01;
            end else begin
                bit_pre_r <= bit_pre_r + 8'h01;
            end
        end else begin
            bit_pre_r <= 8'h00;
            bit_cnt_r <= `BIT_START;
        end
    end

    // ---------------------------------------------------------------
    // mode state machine
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_ACTIVE;
            resume_next <= 1'b0;
        end else begin
            resume_next <= 1'b0;
            case (state_r)
                ST_ACTIVE: begin
                    if (stop_req) begin
                        state_r <= ST_STOP;
                    end else if (sleep_req) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_sleep) begin
                        state_r <= ST_STAB;
                    end
                end
                ST_STOP: begin
                    if (wake_stop) begin
                        state_r <= ST_STAB;
                    end
                end
                ST_STAB: begin
                    if (bit_ovf) begin
                        state_r <= ST_ACTIVE;
                        // pending flags stay set, so with the enable on the
                        // normal response picks them up afterwards
                        resume_next <= !master_irq_en;
                    end
                end
                default: begin
                    state_r <= ST_ACTIVE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // clock and hold controls
    // ---------------------------------------------------------------
    assign cpu_run           = state_r == ST_ACTIVE;
    assign pc_hold           = state_r != ST_ACTIVE;
    assign main_osc_en       = state_r != ST_STOP;
    assign sys_clk_en        = state_r != ST_STOP;
    assign periph_clk_en     = state_r != ST_STOP;
    assign timer_clk_en      = state_r != ST_STOP || ec_mode;
    assign wdt_clk_en        = state_r == ST_ACTIVE || (state_r == ST_STOP && rc_wd);
    assign buzzer_adc_en     = state_r == ST_ACTIVE;
    assign serial_int_clk_en = state_r == ST_ACTIVE;
    assign port_hold         = state_r == ST_STOP;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_sleep_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_ACTIVE && sleep_req && !stop_req) |=> state_r == ST_SLEEP)
        else $error("sleep code did not enter sleep");

    a_stop_needs_code: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_ACTIVE && $rose(state_r == ST_STOP) == 1'b0) ##1
        $rose(state_r == ST_STOP) |-> $past(standby_select_register) == `CODE_STOP
        && $past(stop_exec))
        else $error("stop entered without code and instruction");

    a_other_code_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_ACTIVE && wr_acc && paddr == `OFS_STANDBY_SEL
         && pwdata[7:0] != `CODE_SLEEP && !stop_req) |=> state_r == ST_ACTIVE)
        else $error("other code changed mode");

    a_sleep_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_r == ST_SLEEP |-> !cpu_run && main_osc_en && periph_clk_en)
        else $error("sleep clocks wrong");

    a_stop_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_r == ST_STOP |-> !main_osc_en && !sys_clk_en && !periph_clk_en
        && wdt_clk_en == rc_wd && timer_clk_en == ec_mode && port_hold)
        else $error("stop clocks wrong");

    a_sleep_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_SLEEP && periph_irq) |=> state_r == ST_STAB)
        else $error("sleep missed wake");

    a_stab_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_r == ST_STAB) |-> bit_cnt_r == `BIT_START ##1 !bit_ovf)
        else $error("stabilisation count not from zero");

    a_resume_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        bit_ovf |=> state_r == ST_ACTIVE && resume_next == !$past(master_irq_en))
        else $error("wrong wake exit");

    a_resp_latency: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(resp_busy_r) |-> (!irq_vector) [*8] ##RESP_TAIL (irq_vector || !cpu_run))
        else $error("vector too early");

    a_vector_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(resp_busy_r) |-> $past(master_irq_en) && $past(pending) != 4'h0)
        else $error("ungated response");

    a_pc_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_r == ST_STOP |-> pc_hold && !cpu_run && !irq_vector)
        else $error("pc moved in stop");

endmodule

`default_nettype wire

// ---- design/pwr_save_consts.svh ----
`ifndef PWR_SAVE_CONSTS_SVH
`define PWR_SAVE_CONSTS_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define OFS_STANDBY_SEL   8'h00
`define OFS_CLOCK_CTRL    8'h04
`define OFS_IRQ_CTRL      8'h08
`define OFS_STATUS        8'h0C

// ---------------------------------------------------------------
// codes, fields and reset values
// ---------------------------------------------------------------
`define CODE_SLEEP        8'h0F
`define CODE_STOP         8'h5A
`define STANDBY_RST       8'h00
`define CLOCK_CTRL_RST    8'h00
`define IRQ_CTRL_RST      16'h0000
`define CK_PRESCALE_LSB   0
`define CK_PRESCALE_MSB   2
`define CK_RC_WATCHDOG    3
`define CK_EVENT_COUNTER  4
`define IR_ENABLE_LSB     0
`define IR_ENABLE_MSB     3
`define IR_EDGE_LSB       4
`define IR_EDGE_MSB       11
`define ST_STATE_LSB      0
`define ST_STATE_MSB      3
`define ST_FLAGS_LSB      4
`define ST_FLAGS_MSB      7
`define ST_BIT_LSB        8
`define ST_BIT_MSB        15

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MCYC_DIV_DEF      4
`define RESP_MCYC         12
`define BIT_START         8'h00
`define BIT_LAST          8'hFF

`endif

// ---- design/pwr_save_pkg.sv ----
package pwr_save_pkg;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_SLEEP  = 4'h2,
        ST_STOP   = 4'h4,
        ST_STAB   = 4'h8
    } pwr_state_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_OFF  = 2'h3
    } edge_mode_t;

endpackage

// ---- test/cpu_side.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// cpu core seen from the controller: stop pulses and i-flag
// ---------------------------------------------------------------
module cpu_side (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic cpu_run,
    input  wire logic irq_vector,
    input  wire logic resume_next,
    input  wire logic stop_req,
    input  wire logic ien,
    output logic      stop_exec,
    output logic      master_irq_en,
    output int        n_vec,
    output int        n_res
);
    logic req_q;
    // one stop instruction per request, only while the core fetches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q         <= 1'b0;
            stop_exec     <= 1'b0;
            master_irq_en <= 1'b0;
            n_vec         <= 0;
            n_res         <= 0;
        end else begin
            req_q         <= stop_req;
            stop_exec     <= stop_req & ~req_q & cpu_run;
            master_irq_en <= ien;
            n_vec         <= n_vec + int'(irq_vector);
            n_res         <= n_res + int'(resume_next);
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwr_save_consts.svh"
module tb;
    localparam int MD = 4;
    logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        ex, stop_req = 0, ien = 0, periph_irq = 0, watch_wake = 0, tie0 = 0;
    logic [3:0]  ext_irq_pins = 4'h0;
    logic        pready, pslverr, stop_exec, master_irq_en, cpu_run, pc_hold, main_osc_en;
    logic        sys_clk_en, periph_clk_en, buzzer_adc_en, serial_int_clk_en, port_hold;
    logic        irq_vector, resume_next, timer_clk_en, wdt_clk_en;
    logic [1:0]  irq_vector_src;
    logic [31:0] prdata;
    int          n_vec, n_res, err_total = 0, n_compared = 0, cyc = 0, n;

    always #20 core_clk = ~core_clk;

    power_saving_mode_ctrl #(.MCYC_DIV(MD)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .stop_exec(stop_exec),
        .master_irq_en(master_irq_en), .ext_irq_pins(ext_irq_pins), .periph_irq(periph_irq),
        .event_counter_inputs(tie0), .watch_wake(watch_wake), .wdt_wake(tie0),
        .sio_wake(tie0), .uart_wake(tie0), .cpu_run(cpu_run), .pc_hold(pc_hold),
        .main_osc_en(main_osc_en), .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
        .timer_clk_en(timer_clk_en), .wdt_clk_en(wdt_clk_en), .buzzer_adc_en(buzzer_adc_en),
        .serial_int_clk_en(serial_int_clk_en), .port_hold(port_hold),
        .irq_vector(irq_vector), .irq_vector_src(irq_vector_src), .resume_next(resume_next));

    cpu_side cpu (.core_clk(core_clk), .rst_n(rst_n), .cpu_run(cpu_run),
        .irq_vector(irq_vector), .resume_next(resume_next), .stop_req(stop_req), .ien(ien),
        .stop_exec(stop_exec), .master_irq_en(master_irq_en), .n_vec(n_vec), .n_res(n_res));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard: the whole run needs a few thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        ex = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse_stop();
        @(posedge core_clk);
        stop_req <= 1'b1;
        @(posedge core_clk);
        stop_req <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic wait_run();
        n = 0;
        while (cpu_run !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task automatic t_reset();
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd[3:0], 4'h1);
        chk({cpu_run, main_osc_en, port_hold, timer_clk_en, wdt_clk_en}, 5'h1B);
        apb(1'b0, 8'h10, 32'h0);
        chk({ex, rd}, {1'b1, 32'h0});
        $display("done reset");
    endtask

    task automatic t_other_code();
        apb(1'b1, `OFS_STANDBY_SEL, 32'h33);
        pulse_stop();
        chk(cpu_run, 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd[3:0], 4'h1);
        $display("done other code");
    endtask

    task automatic t_sleep();
        apb(1'b1, `OFS_CLOCK_CTRL, 32'h0);
        apb(1'b1, `OFS_IRQ_CTRL, 32'h053);
        ien <= 1'b1;
        apb(1'b1, `OFS_STANDBY_SEL, {24'h0, `CODE_SLEEP});
        repeat (2) @(posedge core_clk);
        chk({cpu_run, main_osc_en, sys_clk_en, periph_clk_en, serial_int_clk_en}, 5'h0E);
        ext_irq_pins <= 4'h1;
        wait_run();
        chk(n >= 512 && n < 3000, 1'b1);
        repeat (100) @(posedge core_clk);
        chk(n_vec, 1);
        ext_irq_pins <= 4'h0;
        ien <= 1'b0;
        apb(1'b1, `OFS_STANDBY_SEL, {24'h0, `CODE_SLEEP});
        repeat (4) @(posedge core_clk);
        periph_irq <= 1'b1;
        wait_run();
        periph_irq <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(n_res, 1);
        chk(n_vec, 1);
        $display("done sleep");
    endtask

    task automatic t_stop();
        apb(1'b1, `OFS_STANDBY_SEL, {24'h0, `CODE_STOP});
        pulse_stop();
        chk({cpu_run, main_osc_en, sys_clk_en, periph_clk_en, pc_hold, port_hold,
             buzzer_adc_en, timer_clk_en, wdt_clk_en}, 9'h018);
        periph_irq <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk(cpu_run, 1'b0);
        periph_irq <= 1'b0;
        watch_wake <= 1'b1;
        wait_run();
        watch_wake <= 1'b0;
        chk(n >= 512 && n < 3000, 1'b1);
        repeat (4) @(posedge core_clk);
        chk(n_res, 2);
        apb(1'b0, `OFS_STANDBY_SEL, 32'h0);
        chk(rd[7:0], `CODE_STOP);
        $display("done stop");
    endtask

    task automatic t_latency();
        ien <= 1'b1;
        @(posedge core_clk);
        ext_irq_pins <= 4'h3;
        n = 0;
        while (irq_vector !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 12 * MD && n < 500, 1'b1);
        chk(irq_vector_src, 2'h0);
        $display("done latency");
    endtask

    task automatic t_stop_reset();
        apb(1'b1, `OFS_IRQ_CTRL, 32'h0);
        apb(1'b1, `OFS_STANDBY_SEL, {24'h0, `CODE_STOP});
        pulse_stop();
        chk({port_hold, timer_clk_en}, 2'h2);
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, `OFS_STANDBY_SEL, 32'h0);
        chk({cpu_run, rd[7:0]}, {1'b1, `STANDBY_RST});
        $display("done stop reset");
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_other_code();
        t_sleep();
        t_stop();
        t_latency();
        t_stop_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
